/* File: hw/event_select.v */
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "event_select_consts.vh"

module event_select
#(
    parameter COUNT_W = 32
)
(
    input wire CLK,
    input wire RST_B,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // segment rename qualifiers, one-cycle pulses from the pipeline
    input wire ES_RENAME,
    input wire DS_RENAME,
    input wire FS_RENAME,
    input wire GS_RENAME,
    // resource stall qualifiers
    input wire RETIRE_BUFFER_FULL,
    input wire ISSUE_QUEUE_FULL,
    input wire LOAD_LIMIT_HIT,
    input wire LOAD_RETIRE,
    input wire STORE_LIMIT_HIT,
    input wire STORE_COMMIT,
    input wire FENCE_WAIT,
    input wire FP_CONTROL_WRITE_STALL,
    input wire MISPREDICT_RECOVERY,
    // registered copy of the selected condition gated by the enable bit, one cycle late
    output reg EVENT_ACTIVE
);

    // control register fields
    reg [16:0] ctrl_q;
    reg [16:0] ctrl_d;
    wire [7:0] event_code;
    wire [7:0] unit_mask;
    wire count_enable;

    // event counter
    reg [COUNT_W-1:0] count_q;
    reg [COUNT_W-1:0] count_d;

    // load and store limit stall trackers
    reg load_stall_q;
    reg load_stall_d;
    reg store_stall_q;
    reg store_stall_d;

    // condition vectors and selection
    wire [3:0] rename_vec;
    wire [4:0] stall_vec;
    wire load_store_cond;
    reg sel_valid;
    reg sel_hit;

    // apb decode
    wire setup_phase;
    wire access_done;
    wire wr_ctrl;
    wire wr_count;
    reg addr_hit;
    reg [31:0] rd_data;

    assign event_code = ctrl_q[`CTRL_CODE_MSB:`CTRL_CODE_LSB];
    assign unit_mask = ctrl_q[`CTRL_MASK_MSB:`CTRL_MASK_LSB];
    assign count_enable = ctrl_q[`CTRL_ENABLE_BIT];

    // -----------------------------------------------------------------
    // condition gathering
    // -----------------------------------------------------------------

    // rename pulses in unit mask bit order: es, ds, fs, gs
    // the qualifiers are same-clock logic, so they are read directly
    assign rename_vec = {GS_RENAME, FS_RENAME, DS_RENAME, ES_RENAME};

    // a limit stall holds from the hit until its releasing event;
    // a hit in the same cycle as a release keeps the stall alive
    always @*
    begin
        load_stall_d = load_stall_q;
        store_stall_d = store_stall_q;
        if (LOAD_LIMIT_HIT)
        begin
            load_stall_d = 1'b1;
        end
        else if (LOAD_RETIRE)
        begin
            load_stall_d = 1'b0;
        end
        if (STORE_LIMIT_HIT)
        begin
            store_stall_d = 1'b1;
        end
        else if (STORE_COMMIT)
        begin
            store_stall_d = 1'b0;
        end
    end

    // stall trackers
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            load_stall_q <= 1'b0;
            store_stall_q <= 1'b0;
        end
        else
        begin
            load_stall_q <= load_stall_d;
            store_stall_q <= store_stall_d;
        end
    end

    // the hit cycle itself counts, the releasing cycle does not, so a
    // one-cycle wait with hit and release back to back counts once
    assign load_store_cond = (LOAD_LIMIT_HIT | (load_stall_q & ~LOAD_RETIRE))
                           | (STORE_LIMIT_HIT | (store_stall_q & ~STORE_COMMIT))
                           | FENCE_WAIT;

    // stall conditions in unit mask bit order; the recovery level comes
    // from the pipeline, which alone knows when older ops have retired
    assign stall_vec = {MISPREDICT_RECOVERY,
                        FP_CONTROL_WRITE_STALL,
                        load_store_cond,
                        ISSUE_QUEUE_FULL,
                        RETIRE_BUFFER_FULL};

    // -----------------------------------------------------------------
    // event selection
    // -----------------------------------------------------------------

    // only the documented code and mask pairs qualify; anything else
    // selects nothing, so the counter holds instead of counting junk
    always @*
    begin
        sel_valid = 1'b0;
        sel_hit = 1'b0;
        case (event_code)
            `EVT_SEGMENT_RENAME:
            begin
                case (unit_mask)
                    `UM_RENAME_ES:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = rename_vec[0];
                    end
                    `UM_RENAME_DS:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = rename_vec[1];
                    end
                    `UM_RENAME_FS:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = rename_vec[2];
                    end
                    `UM_RENAME_GS:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = rename_vec[3];
                    end
                    `UM_RENAME_ANY:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = |rename_vec;
                    end
                    default:
                    begin
                        sel_valid = 1'b0;
                        sel_hit = 1'b0;
                    end
                endcase
            end
            `EVT_RESOURCE_STALL:
            begin
                case (unit_mask)
                    `UM_RETIRE_QUEUE_FULL:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = stall_vec[0];
                    end
                    `UM_ISSUE_QUEUE_FULL:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = stall_vec[1];
                    end
                    `UM_LOAD_STORE_LIMIT:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = stall_vec[2];
                    end
                    `UM_FP_CONTROL_WRITE:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = stall_vec[3];
                    end
                    `UM_MISPREDICT_RECOVERY:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = stall_vec[4];
                    end
                    `UM_STALL_ANY:
                    begin
                        sel_valid = 1'b1;
                        sel_hit = |stall_vec;
                    end
                    default:
                    begin
                        sel_valid = 1'b0;
                        sel_hit = 1'b0;
                    end
                endcase
            end
            default:
            begin
                sel_valid = 1'b0;
                sel_hit = 1'b0;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // apb slave, zero wait states: pready rises in the access phase
    // -----------------------------------------------------------------

    assign setup_phase = PSEL & ~PENABLE;
    assign access_done = PSEL & PENABLE & PREADY;
    assign wr_ctrl = access_done & PWRITE & (PADDR == `OFS_CTRL);
    assign wr_count = access_done & PWRITE & (PADDR == `OFS_COUNT);

    // read mux, sampled at the end of the setup cycle; reserved bits are zero
    always @*
    begin
        addr_hit = 1'b1;
        rd_data = 32'h00000000;
        case (PADDR)
            `OFS_CTRL:
            begin
                rd_data[16:0] = ctrl_q;
            end
            `OFS_COUNT:
            begin
                rd_data[COUNT_W-1:0] = count_q;
            end
            `OFS_STATUS:
            begin
                rd_data[`STAT_LOAD_STALL_BIT] = load_stall_q;
                rd_data[`STAT_STORE_STALL_BIT] = store_stall_q;
                rd_data[`STAT_SEL_VALID_BIT] = sel_valid;
                rd_data[`STAT_ACTIVE_BIT] = EVENT_ACTIVE;
            end
            default:
            begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // bus answer registers; an unmapped address answers with an error
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end
        else
        begin
            PREADY <= setup_phase;
            PSLVERR <= setup_phase & ~addr_hit;
            if (setup_phase && !PWRITE)
            begin
                PRDATA <= rd_data;
            end
        end
    end

    // -----------------------------------------------------------------
    // control register and counter
    // -----------------------------------------------------------------

    // control register write
    always @*
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d = PWDATA[16:0];
        end
    end

    // a software preset wins over a count in the same cycle, so the value
    // written is exactly what the counter holds on the next cycle
    always @*
    begin
        count_d = count_q;
        if (wr_count)
        begin
            count_d = PWDATA[COUNT_W-1:0];
        end
        else if (count_enable && sel_hit)
        begin
            count_d = count_q + {{(COUNT_W-1){1'b0}}, 1'b1};
        end
    end

    // state registers
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl_q <= `CTRL_RESET;
            count_q <= `COUNT_RESET;
            EVENT_ACTIVE <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            EVENT_ACTIVE <= count_enable & sel_hit;
        end
    end

endmodule

`default_nettype wire

/* File: hw/event_select_consts.vh */
`ifndef EVENT_SELECT_CONSTS_VH
`define EVENT_SELECT_CONSTS_VH

// event codes of the two groups
`define EVT_SEGMENT_RENAME 8'hD5
`define EVT_RESOURCE_STALL 8'hDC

// unit masks of the segment rename group
`define UM_RENAME_ES 8'h01
`define UM_RENAME_DS 8'h02
`define UM_RENAME_FS 8'h04
`define UM_RENAME_GS 8'h08
`define UM_RENAME_ANY 8'h0F

// unit masks of the resource stall group
`define UM_RETIRE_QUEUE_FULL 8'h01
`define UM_ISSUE_QUEUE_FULL 8'h02
`define UM_LOAD_STORE_LIMIT 8'h04
`define UM_FP_CONTROL_WRITE 8'h08
`define UM_MISPREDICT_RECOVERY 8'h10
`define UM_STALL_ANY 8'h1F

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_COUNT 8'h04
`define OFS_STATUS 8'h08

// control register fields
`define CTRL_CODE_LSB 0
`define CTRL_CODE_MSB 7
`define CTRL_MASK_LSB 8
`define CTRL_MASK_MSB 15
`define CTRL_ENABLE_BIT 16

// status register fields
`define STAT_LOAD_STALL_BIT 0
`define STAT_STORE_STALL_BIT 1
`define STAT_SEL_VALID_BIT 2
`define STAT_ACTIVE_BIT 3

// reset values
`define CTRL_RESET 17'h00000
`define COUNT_RESET 32'h00000000

`endif

/* File: tb/event_select_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module event_select_monitor (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic ES_RENAME,
    input wire logic GS_RENAME,
    input wire logic RETIRE_BUFFER_FULL,
    input wire logic LOAD_LIMIT_HIT,
    input wire logic STORE_LIMIT_HIT,
    input wire logic STORE_COMMIT,
    input wire logic FP_CONTROL_WRITE_STALL,
    input wire logic MISPREDICT_RECOVERY,
    input wire logic EVENT_ACTIVE
);
    logic [16:0] c_q;
    // enabled selection only; a disabled word must match nothing
    wire [15:0] s = c_q[16] ? c_q[15:0] : 16'h0000;
    // shadow of the control word, taken at the same edge as the design
    always_ff @(posedge CLK or negedge RST_B)
        if (!RST_B)
            c_q <= 17'h00000;
        else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00)
            c_q <= PWDATA[16:0];
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_st; s == 16'h04DC && STORE_LIMIT_HIT; endsequence
    sequence s_sh; s == 16'h04DC && !STORE_COMMIT; endsequence
    property p_es; s == 16'h01D5 && ES_RENAME |=> EVENT_ACTIVE; endproperty
    property p_any; s == 16'h0FD5 && GS_RENAME |=> EVENT_ACTIVE; endproperty
    property p_rb; s == 16'h01DC && RETIRE_BUFFER_FULL |=> EVENT_ACTIVE; endproperty
    property p_ld; s == 16'h04DC && LOAD_LIMIT_HIT |=> EVENT_ACTIVE; endproperty
    property p_st; s_st ##1 s_sh |=> EVENT_ACTIVE; endproperty
    property p_mr; s == 16'h10DC && MISPREDICT_RECOVERY |=> EVENT_ACTIVE; endproperty
    property p_all; s == 16'h1FDC && FP_CONTROL_WRITE_STALL |=> EVENT_ACTIVE; endproperty
    property p_off; !c_q[16] |=> !EVENT_ACTIVE; endproperty
    a_es: assert property (p_es) else $error("es rename missed");
    a_any: assert property (p_any) else $error("any rename missed");
    a_rb: assert property (p_rb) else $error("retire full missed");
    a_ld: assert property (p_ld) else $error("load limit missed");
    a_st: assert property (p_st) else $error("store stall missed");
    a_mr: assert property (p_mr) else $error("recovery missed");
    a_all: assert property (p_all) else $error("any stall missed");
    a_off: assert property (p_off) else $error("counts while off");
endmodule
bind event_select event_select_monitor mon_inst (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PREADY, .ES_RENAME, .GS_RENAME, .RETIRE_BUFFER_FULL, .LOAD_LIMIT_HIT,
    .STORE_LIMIT_HIT, .STORE_COMMIT, .FP_CONTROL_WRITE_STALL, .MISPREDICT_RECOVERY,
    .EVENT_ACTIVE);
`default_nettype wire

/* File: tb/pipeline_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pipeline_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [12:0] req,
    output logic [12:0] cond
);
    logic [2:0] hold_q;
    // qualifiers move only at the core edge; recovery is held a few cycles
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            cond <= 13'h0000;
            hold_q <= 3'h0;
        end
        else
        begin
            cond <= {req[12] | hold_q != 3'h0, req[11:0]};
            hold_q <= req[12] ? 3'h4 : hold_q - (hold_q != 3'h0);
        end
endmodule
`default_nettype wire

/* File: tb/event_select_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module event_select_tb_top;
    logic CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h00000000, rd, ecnt = 0;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, EVENT_ACTIVE;
    logic [12:0] req = 13'h0000;
    wire [12:0] c;
    logic [16:0] ectl = 0;
    logic lf = 0, sf = 0, eact = 0, run = 0, er;
    int err_total = 0, n_tests = 0, seed = 32'h7933, k;
    logic [16:0] sel [15] = '{17'h101D5, 17'h102D5, 17'h104D5, 17'h108D5, 17'h10FD5,
        17'h101DC, 17'h102DC, 17'h104DC, 17'h108DC, 17'h110DC, 17'h11FDC, 17'h110D5,
        17'h10FDC, 17'h101AA, 17'h01FDC};
    always #2.5 CLK = ~CLK;
    pipeline_model pipeline_model_inst (.clk(CLK), .rst_b(RST_B), .req(req), .cond(c));
    event_select event_select_inst (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ES_RENAME(c[0]), .DS_RENAME(c[1]),
        .FS_RENAME(c[2]), .GS_RENAME(c[3]), .RETIRE_BUFFER_FULL(c[4]),
        .ISSUE_QUEUE_FULL(c[5]), .LOAD_LIMIT_HIT(c[6]), .LOAD_RETIRE(c[7]),
        .STORE_LIMIT_HIT(c[8]), .STORE_COMMIT(c[9]), .FENCE_WAIT(c[10]),
        .FP_CONTROL_WRITE_STALL(c[11]), .MISPREDICT_RECOVERY(c[12]), .EVENT_ACTIVE);
    // selected condition; an all-ones vector tells whether a selection exists
    function automatic logic hit(logic [16:0] t, logic [12:0] v, logic l, logic s);
        logic ls;
        ls = v[6] | l & ~v[7] | v[8] | s & ~v[9] | v[10];
        case (t[15:0])
            16'h01D5: hit = v[0];
            16'h02D5: hit = v[1];
            16'h04D5: hit = v[2];
            16'h08D5: hit = v[3];
            16'h0FD5: hit = |v[3:0];
            16'h01DC: hit = v[4];
            16'h02DC: hit = v[5];
            16'h04DC: hit = ls;
            16'h08DC: hit = v[11];
            16'h10DC: hit = v[12];
            16'h1FDC: hit = v[4] | v[5] | ls | v[11] | v[12];
            default: hit = 0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        k = 0;
        do
        begin
            @(posedge CLK);
            k++;
        end
        while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        // no wait states: the answer must come in the first access cycle
        chk(k, 1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(er, a > 8'h08);
        chk(rd, e);
    endtask
    // one selection: count under random traffic, stop, read back
    task automatic scen(input logic [16:0] t);
        apb(1, 8'h00, {15'h0, t});
        run <= 1;
        apb(1, 8'h04, 32'hFFFFFFF0);
        repeat (40) @(posedge CLK);
        run <= 0;
        repeat (4) @(posedge CLK);
        apb(1, 8'h00, {16'h0, t[15:0]});
        repeat (2) @(posedge CLK);
        rdc(8'h04, ecnt);
        rdc(8'h08, {eact, hit(t, 13'h1FFF, 0, 0), sf, lf});
    endtask
    // reference model, one step per edge; a register write beats a count
    always @(posedge CLK or negedge RST_B)
        if (!RST_B)
        begin
            ectl = 0;
            ecnt = 0;
            lf = 0;
            sf = 0;
            eact = 0;
        end
        else
        begin
            chk(EVENT_ACTIVE, eact);
            eact = ectl[16] & hit(ectl, c, lf, sf);
            ecnt = ecnt + eact;
            if (PSEL & PENABLE & PREADY & PWRITE & PADDR == 8'h00)
                ectl = PWDATA[16:0];
            if (PSEL & PENABLE & PREADY & PWRITE & PADDR == 8'h04)
                ecnt = PWDATA;
            lf = c[6] | lf & ~c[7];
            sf = c[8] | sf & ~c[9];
        end
    // sparse random qualifiers while a selection runs
    always @(posedge CLK)
        req <= run ? 13'($random(seed) & $random(seed)) : 13'h0000;
    task automatic test_done;
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge CLK);
        RST_B <= 1;
        rdc(8'h00, 0);
        rdc(8'h04, 0);
        rdc(8'h0C, 0);
        apb(1, 8'h08, 32'hFFFFFFFF);
        chk(er, 0);
        for (int i = 0; i < 15; i++)
            scen(sel[i]);
        test_done;
    end
    // hang guard, well past the expected run length
    initial
    begin
        #50000;
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
